// File: shared/swb_pkg.sv
/*
  Shared constants for the SDRAM posting write buffer and two-line read
  buffer: geometry, register offsets, field positions and reset values.
  Assumes a single system clock and a synchronous active-high reset.
*/
package swb_pkg;

  // Write buffer geometry: one doubleword per level.
  localparam int WB_DEPTH = 32;
  localparam int WB_IDX_W = 5;
  localparam logic [5:0] WB_COUNT_FULL = 6'h20;
  localparam logic [5:0] WB_COUNT_EMPTY = 6'h00;

  // Doubleword address is system address bits 27..2.
  localparam int ADDR_W = 26;
  localparam int LINE_W = 24;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int TRACE_W = 3;

  // Read buffer: two lines of four doublewords each.
  localparam int RB_LINES = 2;
  localparam int RB_IDX_W = 3;
  localparam logic [1:0] FILL_LAST = 2'h3;
  localparam logic [1:0] LINE_FIRST_DW = 2'h0;

  // Register offsets and reset values.
  localparam logic [7:0] OFF_SDRAM_CONTROL = 8'h10;
  localparam logic [7:0] OFF_BUFFER_CONTROL = 8'h40;
  localparam logic [7:0] RST_SDRAM_CONTROL = 8'h00;
  localparam logic [7:0] RST_BUFFER_CONTROL = 8'h00;

  // Field positions inside the two registers.
  localparam int CTL_TRACE_BIT = 4;
  localparam int BC_WB_EN_BIT = 0;
  localparam int BC_WMARK_LSB = 1;
  localparam int BC_RA_EN_BIT = 3;
  localparam int BC_FLUSH_BIT = 4;
  localparam int BC_EMPTY_BIT = 5;

  // Master codes presented with every request.
  localparam logic [1:0] MSTR_CPU = 2'h0;
  localparam logic [1:0] MSTR_PCI = 2'h1;
  localparam logic [1:0] MSTR_DMA = 2'h2;

endpackage : swb_pkg

// File: hw/swb_mem.sv
/*
  Small byte-writable memory with a registered read port, used for the
  write buffer data store and the read buffer line store.
  Assumes one clock; read data appear one edge after the read address.
*/
module swb_mem #(
  parameter int ADDR_BITS = 5
) (
  input wire logic mclk_in,
  input wire logic [3:0] we_in,
  input wire logic [ADDR_BITS-1:0] waddr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [ADDR_BITS-1:0] raddr_in,
  output logic [31:0] rdata_out
);

  logic [31:0] store [2**ADDR_BITS];

  // Byte lanes are written independently so merges touch only their bytes.
  always_ff @(posedge mclk_in) begin
    for (int b = 0; b < 4; b++) begin
      if (we_in[b]) begin
        store[waddr_in][8*b +: 8] <= wdata_in[8*b +: 8];
      end
    end
  end

  // Registered read; a write to the same word shows on the next read.
  always_ff @(posedge mclk_in) begin
    rdata_out <= store[raddr_in];
  end

endmodule : swb_mem

// File: hw/swb_buffer.sv
/*
  SDRAM write buffer (32-level snooping FIFO) and two-line read buffer
  with read-ahead, sitting between the system masters and the SDRAM
  controller, plus its two control registers and the trace pin mux.
  Assumes masters hold a request until acknowledged and drop it in the
  cycle the acknowledge is seen; the SDRAM side completes one doubleword
  per cycle in which request and acknowledge are both high.
*/
module swb_buffer (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic m_req_in,
  input wire logic m_we_in,
  input wire logic [25:0] m_addr_in,
  input wire logic [3:0] m_be_in,
  input wire logic [31:0] m_wdata_in,
  input wire logic m_burst_in,
  input wire logic [1:0] m_master_in,
  output logic m_ack_out,
  output logic [31:0] m_rdata_out,
  output logic sd_req_out,
  output logic sd_we_out,
  output logic [25:0] sd_addr_out,
  output logic [3:0] sd_be_out,
  output logic [31:0] sd_wdata_out,
  input wire logic sd_ack_in,
  input wire logic [31:0] sd_rdata_in,
  input wire logic [2:0] default_pins_in,
  output logic [2:0] master_trace_pins_out
);

  typedef enum logic [3:0] {
    SWB_IDLE, SWB_DR_RD, SWB_DR_LD, SWB_DR_WAIT, SWB_WT_WAIT,
    SWB_FILL, SWB_RD_MEM, SWB_RESP, SWB_HOLD
  } swb_state_t;

  // Line tag compare, used for hits, invalidation and prefetch checks.
  function automatic logic swb_line_match(input logic valid,
      input logic [23:0] tag, input logic [25:0] addr);
    return valid && (tag == addr[25:2]);
  endfunction : swb_line_match

  // One trace bit per master so merged levels can show several owners.
  function automatic logic [2:0] swb_master_bit(input logic [1:0] code);
    logic [2:0] bits;
    bits = 3'h0;
    if (code == swb_pkg::MSTR_CPU) bits = 3'h1;
    if (code == swb_pkg::MSTR_PCI) bits = 3'h2;
    if (code == swb_pkg::MSTR_DMA) bits = 3'h4;
    return bits;
  endfunction : swb_master_bit

  swb_state_t state;
  logic [25:0] ent_tag [swb_pkg::WB_DEPTH];
  logic [3:0] ent_be [swb_pkg::WB_DEPTH];
  logic [2:0] ent_trace [swb_pkg::WB_DEPTH];
  logic [31:0] ent_valid;
  logic [4:0] head;
  logic [4:0] tail;
  logic [5:0] count;
  logic wb_en;
  logic ra_en;
  logic [1:0] wmark;
  logic trace_en;
  logic flush_pend;
  logic [23:0] rb_tag [swb_pkg::RB_LINES];
  logic [1:0] rb_valid;
  logic rd_line_q;
  logic [23:0] rp_line;
  logic [1:0] fill_cnt;
  logic pf_q;
  logic snoop_hit_q;
  logic [3:0] snoop_be_q;
  logic [31:0] wb_rdata;
  logic [31:0] rb_rdata;
  logic [31:0] merged;
  logic [4:0] cam_idx;

  // Associative compare of the master address, and of the line being filled, against every level.
  wire [31:0] hit_vec;
  wire [31:0] line_vec;
  genvar gi;
  generate
    for (gi = 0; gi < swb_pkg::WB_DEPTH; gi++) begin : g_cam
      assign hit_vec[gi] = wb_en && ent_valid[gi] &&
                           (ent_tag[gi] == m_addr_in);
      assign line_vec[gi] = ent_valid[gi] && (ent_tag[gi][25:2] == rp_line);
    end
  endgenerate

  // Only one level can match a given doubleword, so a simple scan is safe.
  always_comb begin
    cam_idx = 5'h00;
    for (int i = 0; i < swb_pkg::WB_DEPTH; i++) begin
      if (hit_vec[i]) cam_idx = 5'(i);
    end
  end

  // Status and decision terms.
  wire cam_hit = |hit_vec;
  wire line_dirty = |line_vec;
  wire wb_empty = (count == swb_pkg::WB_COUNT_EMPTY);
  wire wb_full = (count == swb_pkg::WB_COUNT_FULL);
  wire must_drain = !wb_empty && (!wb_en || flush_pend);
  wire rd_req = m_req_in && !m_we_in;
  wire wr_req = m_req_in && m_we_in;
  wire wr_post = wr_req && wb_en && (cam_hit || !wb_full);
  wire wr_thru = wr_req && !wb_en;
  wire in_idle = (state == SWB_IDLE);
  wire post_now = in_idle && !must_drain && !rd_req && wr_post;
  wire thru_now = in_idle && !must_drain && !rd_req && wr_thru;
  wire drain_done = (state == SWB_DR_WAIT) && sd_ack_in;
  wire fill_ack = (state == SWB_FILL) && sd_ack_in;
  wire fill_done = fill_ack && (fill_cnt == swb_pkg::FILL_LAST);

  // Read buffer lookup, victim choice and the line after the request.
  wire rb_hit0 = swb_line_match(rb_valid[0], rb_tag[0], m_addr_in);
  wire rb_hit1 = swb_line_match(rb_valid[1], rb_tag[1], m_addr_in);
  wire rb_hit = rb_hit0 || rb_hit1;
  wire victim = !rb_valid[0] ? 1'b0 : (!rb_valid[1] ? 1'b1 : !rd_line_q);
  wire [23:0] next_line = 24'(m_addr_in[25:2] + 24'h000001);
  wire [25:0] next_addr = {next_line, swb_pkg::LINE_FIRST_DW};
  wire pf_skip = swb_line_match(rb_valid[0], rb_tag[0], next_addr) ||
                 swb_line_match(rb_valid[1], rb_tag[1], next_addr);
  wire pf_go = ra_en && m_burst_in && !pf_skip;

  // Memory port steering: drains read the head, snoops read the hit.
  wire [4:0] wb_raddr = (state == SWB_DR_RD) ? head : cam_idx;
  wire [3:0] wb_we = post_now ? m_be_in : 4'h0;
  wire [4:0] wb_waddr = cam_hit ? cam_idx : tail;
  wire rb_rsel = in_idle ? rb_hit1 : rd_line_q;
  wire [2:0] rb_raddr = {rb_rsel, m_addr_in[1:0]};
  wire [3:0] rb_we = fill_ack ? 4'hF : 4'h0;
  wire [2:0] rb_waddr = {rd_line_q, sd_addr_out[1:0]};

  swb_mem #(.ADDR_BITS(swb_pkg::WB_IDX_W)) u_wb_data (
    .mclk_in(mclk_in),
    .we_in(wb_we),
    .waddr_in(wb_waddr),
    .wdata_in(m_wdata_in),
    .raddr_in(wb_raddr),
    .rdata_out(wb_rdata)
  );

  swb_mem #(.ADDR_BITS(swb_pkg::RB_IDX_W)) u_rb_data (
    .mclk_in(mclk_in),
    .we_in(rb_we),
    .waddr_in(rb_waddr),
    .wdata_in(sd_rdata_in),
    .raddr_in(rb_raddr),
    .rdata_out(rb_rdata)
  );

  // Read-merge: newer posted bytes override what SDRAM returned.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      merged[8*b +: 8] = (snoop_hit_q && snoop_be_q[b]) ?
                         wb_rdata[8*b +: 8] : rb_rdata[8*b +: 8];
    end
  end

  // Snoop result is sampled alongside the memory read it belongs to.
  always_ff @(posedge mclk_in) begin
    snoop_hit_q <= cam_hit;
    snoop_be_q <= ent_be[cam_idx];
  end

  // Level contents: merge into a hit level or fill the tail level.
  always_ff @(posedge mclk_in) begin
    if (post_now && cam_hit) begin
      ent_be[cam_idx] <= ent_be[cam_idx] | m_be_in;
      ent_trace[cam_idx] <= ent_trace[cam_idx] |
                            swb_master_bit(m_master_in);
    end else if (post_now) begin
      ent_tag[tail] <= m_addr_in;
      ent_be[tail] <= m_be_in;
      ent_trace[tail] <= swb_master_bit(m_master_in);
    end
  end

  // FIFO pointers and level valid bits; drains leave in arrival order.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ent_valid <= 32'h0000_0000;
      head <= 5'h00;
      tail <= 5'h00;
      count <= swb_pkg::WB_COUNT_EMPTY;
    end else if (post_now && !cam_hit) begin
      ent_valid[tail] <= 1'b1;
      tail <= tail + 5'h01;
      count <= count + 6'h01;
    end else if (drain_done) begin
      ent_valid[head] <= 1'b0;
      head <= head + 5'h01;
      count <= count - 6'h01;
    end
  end

  // Software registers; the flush request set wins over its completion.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wb_en <= swb_pkg::RST_BUFFER_CONTROL[swb_pkg::BC_WB_EN_BIT];
      ra_en <= swb_pkg::RST_BUFFER_CONTROL[swb_pkg::BC_RA_EN_BIT];
      wmark <= swb_pkg::RST_BUFFER_CONTROL[swb_pkg::BC_WMARK_LSB +: 2];
      flush_pend <= 1'b0;
      trace_en <= swb_pkg::RST_SDRAM_CONTROL[swb_pkg::CTL_TRACE_BIT];
    end else begin
      if (reg_wr_in && reg_addr_in == swb_pkg::OFF_BUFFER_CONTROL) begin
        wb_en <= reg_wdata_in[swb_pkg::BC_WB_EN_BIT];
        ra_en <= reg_wdata_in[swb_pkg::BC_RA_EN_BIT];
        wmark <= reg_wdata_in[swb_pkg::BC_WMARK_LSB +: 2];
      end
      if (reg_wr_in && reg_addr_in == swb_pkg::OFF_SDRAM_CONTROL) begin
        trace_en <= reg_wdata_in[swb_pkg::CTL_TRACE_BIT];
      end
      if (reg_wr_in && reg_addr_in == swb_pkg::OFF_BUFFER_CONTROL &&
          reg_wdata_in[swb_pkg::BC_FLUSH_BIT]) begin
        flush_pend <= 1'b1;
      end else if (wb_empty) begin
        flush_pend <= 1'b0;
      end
    end
  end

  // Read-back: flush bit stays high until the buffer has emptied.
  wire [7:0] ctl_view = 8'({trace_en, 4'h0}) & 8'h10;
  wire [7:0] bc_view = {2'h0, wb_empty, flush_pend, ra_en, wmark, wb_en};
  wire [7:0] reg_view =
    (reg_addr_in == swb_pkg::OFF_SDRAM_CONTROL) ? ctl_view :
    (reg_addr_in == swb_pkg::OFF_BUFFER_CONTROL) ? bc_view : 8'h00;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) reg_rdata_out <= 8'h00;
    else reg_rdata_out <= reg_view;
  end

  // Trace on: pins show the draining level's owners, else zero; trace off: the default signals.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      master_trace_pins_out <= 3'h0;
    end else if (trace_en) begin
      master_trace_pins_out <= (state == SWB_DR_WAIT) ?
                               ent_trace[head] : 3'h0;
    end else begin
      master_trace_pins_out <= default_pins_in;
    end
  end

  // Read buffer tags: fills clear a line until it is complete, writes and
  // drains that touch a line drop it. A line that still has posted data
  // pending is not kept, since its copy would be stale.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rb_valid <= 2'h0;
    end else if (in_idle && !must_drain && rd_req && !rb_hit) begin
      rb_valid[victim] <= 1'b0;
      rb_tag[victim] <= m_addr_in[25:2];
    end else if (state == SWB_RESP && pf_go) begin
      rb_valid[!rd_line_q] <= 1'b0;
      rb_tag[!rd_line_q] <= next_line;
    end else if (fill_done) begin
      rb_valid[rd_line_q] <= !line_dirty;
    end else if (post_now || thru_now) begin
      for (int k = 0; k < 2; k++) begin
        if (swb_line_match(rb_valid[k], rb_tag[k], m_addr_in)) begin
          rb_valid[k] <= 1'b0;
        end
      end
    end else if (drain_done) begin
      for (int k = 0; k < 2; k++) begin
        if (swb_line_match(rb_valid[k], rb_tag[k], ent_tag[head])) begin
          rb_valid[k] <= 1'b0;
        end
      end
    end
  end

  // Doubleword counter for line fills.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || state != SWB_FILL) fill_cnt <= 2'h0;
    else if (sd_ack_in) fill_cnt <= fill_cnt + 2'h1;
  end

  // Sequencer: a disabled or flushing buffer drains first, then reads, then
  // writes; a full buffer drains one level before the waiting post is taken.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state <= SWB_IDLE;
      m_ack_out <= 1'b0;
      m_rdata_out <= 32'h0000_0000;
      sd_req_out <= 1'b0;
      sd_we_out <= 1'b0;
      sd_addr_out <= 26'h000_0000;
      sd_be_out <= 4'h0;
      sd_wdata_out <= 32'h0000_0000;
      rd_line_q <= 1'b0;
      rp_line <= 24'h00_0000;
      pf_q <= 1'b0;
    end else begin
      m_ack_out <= 1'b0;
      unique case (state)
        SWB_IDLE: begin
          if (must_drain) begin
            state <= SWB_DR_RD;
          end else if (rd_req && rb_hit) begin
            rd_line_q <= rb_hit1;
            state <= SWB_RESP;
          end else if (rd_req) begin
            rd_line_q <= victim;
            rp_line <= m_addr_in[25:2];
            pf_q <= 1'b0;
            sd_req_out <= 1'b1;
            sd_we_out <= 1'b0;
            sd_addr_out <= m_addr_in;
            sd_be_out <= 4'hF;
            state <= SWB_FILL;
          end else if (wr_thru) begin
            sd_req_out <= 1'b1;
            sd_we_out <= 1'b1;
            sd_addr_out <= m_addr_in;
            sd_be_out <= m_be_in;
            sd_wdata_out <= m_wdata_in;
            state <= SWB_WT_WAIT;
          end else if (wr_post) begin
            m_ack_out <= 1'b1;
            state <= SWB_HOLD;
          end else if (wr_req) begin
            state <= SWB_DR_RD;
          end
        end
        SWB_DR_RD: state <= SWB_DR_LD;
        SWB_DR_LD: begin
          sd_req_out <= 1'b1;
          sd_we_out <= 1'b1;
          sd_addr_out <= ent_tag[head];
          sd_be_out <= ent_be[head];
          sd_wdata_out <= wb_rdata;
          state <= SWB_DR_WAIT;
        end
        SWB_DR_WAIT: begin
          if (sd_ack_in) begin
            sd_req_out <= 1'b0;
            state <= SWB_IDLE;
          end
        end
        SWB_WT_WAIT: begin
          if (sd_ack_in) begin
            sd_req_out <= 1'b0;
            m_ack_out <= 1'b1;
            state <= SWB_HOLD;
          end
        end
        SWB_FILL: begin
          if (sd_ack_in) begin
            sd_addr_out[1:0] <= sd_addr_out[1:0] + 2'h1;
          end
          if (fill_done) begin
            sd_req_out <= 1'b0;
            state <= pf_q ? SWB_IDLE : SWB_RD_MEM;
          end
        end
        SWB_RD_MEM: state <= SWB_RESP;
        SWB_RESP: begin
          m_rdata_out <= merged;
          m_ack_out <= 1'b1;
          if (pf_go) begin
            rd_line_q <= !rd_line_q;
            rp_line <= next_line;
            pf_q <= 1'b1;
            sd_req_out <= 1'b1;
            sd_we_out <= 1'b0;
            sd_addr_out <= next_addr;
            sd_be_out <= 4'hF;
            state <= SWB_FILL;
          end else begin
            state <= SWB_HOLD;
          end
        end
        SWB_HOLD: state <= SWB_IDLE;
      endcase
    end
  end

endmodule : swb_buffer

// File: bench/swb_sdram_model.sv
/*
  SDRAM controller stand-in: a 256-word memory, one beat per acknowledge.
  Assumes the buffer holds each request until it is acknowledged.
*/
module swb_sdram_model (
  input wire logic mclk_in,
  input wire logic hold_in,
  input wire logic sd_req_in,
  input wire logic sd_we_in,
  input wire logic [25:0] sd_addr_in,
  input wire logic [3:0] sd_be_in,
  input wire logic [31:0] sd_wdata_in,
  output logic sd_ack_out,
  output logic [31:0] sd_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [256];
  logic [7:0] wa;
  int n_rd;
  initial begin
    n_rd = 0;
    for (int i = 0; i < 256; i++) mem[i] = 32'hA5000000 | 32'(i);
  end
  // Hold stalls every beat; data away from an ack is inverted, never stale.
  assign wa = sd_addr_in[7:0];
  assign sd_ack_out = sd_req_in & ~hold_in;
  assign sd_rdata_out = sd_ack_out ? mem[wa] : ~mem[wa];
  // Writes land per byte enable at the ack edge; read beats are counted.
  always @(posedge mclk_in) begin
    for (int b = 0; b < 4; b++) begin
      if (sd_ack_out && sd_we_in && sd_be_in[b])
        mem[wa][8*b+:8] <= sd_wdata_in[8*b+:8];
    end
    if (sd_ack_out && !sd_we_in) n_rd <= n_rd + 1;
  end
endmodule : swb_sdram_model

// File: bench/swb_buffer_asserts.sv
/*
  Port assertions for swb_buffer, bound to it below.
  Assumes one clock and the synchronous active-high reset.
*/
module swb_buffer_asserts (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic m_req_in,
  input wire logic m_we_in,
  input wire logic m_ack_out,
  input wire logic sd_req_out,
  input wire logic sd_we_out,
  input wire logic [25:0] sd_addr_out,
  input wire logic sd_ack_in,
  input wire logic [2:0] default_pins_in,
  input wire logic [2:0] master_trace_pins_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic trace_q;
  logic wb_en_q;
  // Mirror of the two enables, so checks know the mode without internals.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      trace_q <= 1'b0;
      wb_en_q <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == swb_pkg::OFF_SDRAM_CONTROL)
        trace_q <= reg_wdata_in[swb_pkg::CTL_TRACE_BIT];
      if (reg_addr_in == swb_pkg::OFF_BUFFER_CONTROL)
        wb_en_q <= reg_wdata_in[swb_pkg::BC_WB_EN_BIT];
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // A line fill is a read beat followed by another read request in the same line.
  sequence s_rd_beat;
    sd_req_out && sd_ack_in && !sd_we_out;
  endsequence
  sequence s_same_line;
    sd_req_out && !sd_we_out && sd_addr_out[25:2] == $past(sd_addr_out[25:2]);
  endsequence
  a_reset_quiet: assert property ($past(sys_rst_in) |-> !m_ack_out &&
    !sd_req_out && reg_rdata_out == 8'h00 && master_trace_pins_out == 3'h0)
    else $error("outputs not quiet after reset");
  a_ack_pulse: assert property (m_ack_out |=> !m_ack_out)
    else $error("master ack longer than one cycle");
  a_ack_has_req: assert property (m_ack_out |-> $past(m_req_in))
    else $error("master ack without a request");
  a_sd_req_stands: assert property (sd_req_out && !sd_ack_in |=>
    sd_req_out && $stable(sd_addr_out) && $stable(sd_we_out))
    else $error("SDRAM request changed before ack");
  a_fill_order: assert property (s_rd_beat ##1 s_same_line |->
    sd_addr_out[1:0] == $past(sd_addr_out[1:0]) + 2'h1)
    else $error("line fill not in wrapping order");
  a_write_through: assert property (m_ack_out && m_we_in && !wb_en_q |->
    $past(sd_req_out && sd_ack_in && sd_we_out))
    else $error("direct write acked before SDRAM write");
  a_unmapped_zero: assert property (
    $past(reg_addr_in) != swb_pkg::OFF_SDRAM_CONTROL &&
    $past(reg_addr_in) != swb_pkg::OFF_BUFFER_CONTROL |-> reg_rdata_out == 8'h00)
    else $error("unmapped offset read not zero");
  a_ctrl_readback: assert property (
    $past(reg_addr_in) == swb_pkg::OFF_SDRAM_CONTROL && !$past(reg_wr_in) |->
    reg_rdata_out == (8'(trace_q) << swb_pkg::CTL_TRACE_BIT))
    else $error("control register readback wrong");
  a_wb_en_readback: assert property (
    $past(reg_addr_in) == swb_pkg::OFF_BUFFER_CONTROL && !$past(reg_wr_in) |->
    reg_rdata_out[swb_pkg::BC_WB_EN_BIT] == wb_en_q)
    else $error("buffer enable readback wrong");
  a_pins_default: assert property (!$past(trace_q) && !$past(sys_rst_in) |->
    master_trace_pins_out == $past(default_pins_in))
    else $error("pins not default with trace off");
endmodule : swb_buffer_asserts

bind swb_buffer swb_buffer_asserts swb_buffer_asserts_i (.mclk_in, .sys_rst_in,
  .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .m_req_in, .m_we_in,
  .m_ack_out, .sd_req_out, .sd_we_out, .sd_addr_out, .sd_ack_in,
  .default_pins_in, .master_trace_pins_out);

// File: bench/swb_buffer_tb.sv
/*
  Self-checking bench for swb_buffer with the SDRAM stand-in.
  Assumes a 20 MHz clock; inputs move 1 ns after each rising edge.
*/
module swb_buffer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} swb_row_t;
  logic mclk_in, sys_rst_in, reg_wr_in, m_req_in, m_we_in, m_burst_in;
  logic m_ack_out, sd_req_out, sd_we_out, sd_ack_in, hold_in, wr_beat, trace_on;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, r;
  logic [25:0] m_addr_in, sd_addr_out;
  logic [3:0] m_be_in, sd_be_out;
  logic [31:0] m_wdata_in, m_rdata_out, sd_wdata_out, sd_rdata_in, rd;
  logic [1:0] m_master_in;
  logic [2:0] default_pins_in, master_trace_pins_out, exp_trace;
  int miscompares = 0, n_compared = 0, cyc, base;
  // Watermark bits read back; bit 5 shows the empty buffer.
  swb_row_t rows[7] = '{'{8'h40, 8'h09, 8'h29}, '{8'h40, 8'h06, 8'h26},
    '{8'h40, 8'h08, 8'h28}, '{8'h10, 8'h10, 8'h10}, '{8'h10, 8'hEF, 8'h00},
    '{8'h30, 8'hFF, 8'h00}, '{8'h40, 8'h00, 8'h20}};
  swb_buffer swb_buffer_i (.mclk_in, .sys_rst_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .reg_rdata_out, .m_req_in, .m_we_in, .m_addr_in, .m_be_in,
    .m_wdata_in, .m_burst_in, .m_master_in, .m_ack_out, .m_rdata_out,
    .sd_req_out, .sd_we_out, .sd_addr_out, .sd_be_out, .sd_wdata_out,
    .sd_ack_in, .sd_rdata_in, .default_pins_in, .master_trace_pins_out);
  swb_sdram_model swb_sdram_model_i (.mclk_in, .hold_in,
    .sd_req_in(sd_req_out), .sd_we_in(sd_we_out), .sd_addr_in(sd_addr_out),
    .sd_be_in(sd_be_out), .sd_wdata_in(sd_wdata_out), .sd_ack_out(sd_ack_in),
    .sd_rdata_out(sd_rdata_in));
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic summarize();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_cyc(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("Error at %0t: cycles %h not in %h..%h", $time, got, lo, hi);
    end
  endtask : cmp_cyc
  task automatic give_up();
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    summarize();
  endtask : give_up
  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
    tick();
    reg_wr_in = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    tick();
    reg_addr_in = a;
    tick();
    d = reg_rdata_out;
  endtask : reg_rd
  // The request stands until the edge that samples the ack, then drops.
  task automatic acc(input logic we, input logic [25:0] a, input logic [3:0] be,
      input logic [31:0] d, input logic bu, input logic [1:0] ms);
    int k;
    tick();
    {m_req_in, m_we_in, m_addr_in, m_be_in, m_wdata_in, m_burst_in,
      m_master_in} = {1'b1, we, a, be, d, bu, ms};
    k = 0;
    do begin
      tick();
      k++;
    end while (m_ack_out !== 1'b1 && k < 400);
    if (k >= 400) give_up();
    cyc = k;
    rd = m_rdata_out;
    tick();
    m_req_in = 1'b0;
  endtask : acc
  task automatic rd_chk(input logic [25:0] a, input logic bu,
      input logic [31:0] exp, input int lo, input int hi);
    acc(1'b0, a, 4'h0, 32'h0, bu, swb_pkg::MSTR_CPU);
    cmp(rd, exp);
    cmp_cyc(cyc, lo, hi);
  endtask : rd_chk
  task automatic wr_chk(input logic [25:0] a, input logic [3:0] be,
      input logic [31:0] d, input logic [1:0] ms);
    acc(1'b1, a, be, d, 1'b0, ms);
    cmp_cyc(cyc, 1, 1);
  endtask : wr_chk
  task automatic release_hold();
    repeat (20) tick();
    hold_in = 1'b0;
  endtask : release_hold
  // Polling is bounded so a flush that never ends cannot hang the run.
  task automatic flush_wait();
    int k;
    k = 0;
    do begin
      reg_rd(swb_pkg::OFF_BUFFER_CONTROL, r);
      k++;
    end while (r[swb_pkg::BC_FLUSH_BIT] !== 1'b0 && k < 200);
    if (k >= 200) give_up();
  endtask : flush_wait
  // One cycle after each drain beat the pins show trace bits or defaults.
  always @(negedge mclk_in) begin
    if (wr_beat)
      cmp(32'(master_trace_pins_out), 32'(trace_on ? exp_trace : default_pins_in));
    wr_beat = sd_req_out & sd_ack_in & sd_we_out;
  end
  initial begin
    {sys_rst_in, reg_wr_in, reg_addr_in, reg_wdata_in} = {1'b1, 17'h0};
    {m_req_in, m_we_in, m_addr_in, m_be_in, m_wdata_in, m_burst_in,
      m_master_in} = 67'h0;
    {hold_in, trace_on, exp_trace, default_pins_in} = {5'h0, 3'h5};
    repeat (8) @(posedge mclk_in);
    #1 sys_rst_in = 1'b0;
    reg_rd(8'h40, r);
    cmp(32'(r), 32'h20);
    reg_rd(8'h10, r);
    cmp(32'(r), 32'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].d);
      reg_rd(rows[i].a, r);
      cmp(32'(r), 32'(rows[i].e));
    end
    $display("test register rows done");
    // Buffer off: writes go straight through; misses fill a whole line.
    acc(1'b1, 26'h12, 4'hF, 32'h11112222, 1'b0, swb_pkg::MSTR_CPU);
    cmp_cyc(cyc, 2, 20);
    cmp(swb_sdram_model_i.mem[8'h12], 32'h11112222);
    rd_chk(26'h12, 1'b0, 32'h11112222, 7, 7);
    rd_chk(26'h10, 1'b0, 32'hA5000010, 2, 2);
    rd_chk(26'h20, 1'b0, 32'hA5000020, 7, 7);
    rd_chk(26'h13, 1'b0, 32'hA5000013, 2, 2);
    $display("test direct path done");
    // Three masters merge into one level; a read overlays the posted bytes.
    reg_wr(8'h40, 8'h01);
    hold_in = 1'b1;
    wr_chk(26'h30, 4'h3, 32'h0000BEEF, swb_pkg::MSTR_CPU);
    wr_chk(26'h30, 4'hC, 32'hCAFE0000, swb_pkg::MSTR_PCI);
    wr_chk(26'h30, 4'h1, 32'h000000AA, swb_pkg::MSTR_DMA);
    hold_in = 1'b0;
    rd_chk(26'h30, 1'b0, 32'hCAFEBEAA, 7, 20);
    reg_wr(8'h40, 8'h11);
    flush_wait();
    cmp(swb_sdram_model_i.mem[8'h30], 32'hCAFEBEAA);
    $display("test merge done");
    // Fill all levels while SDRAM stalls; the extra write must wait.
    reg_wr(8'h10, 8'h10);
    {trace_on, exp_trace, hold_in} = {1'b1, 3'h2, 1'b1};
    for (int i = 0; i < 32; i++)
      wr_chk(26'h40 + 26'(i), 4'hF, 32'hD0000000 + 32'(i), swb_pkg::MSTR_PCI);
    fork
      acc(1'b1, 26'h60, 4'hF, 32'hD0000020, 1'b0, swb_pkg::MSTR_PCI);
      release_hold();
    join
    cmp_cyc(cyc, 20, 400);
    reg_wr(8'h40, 8'h11);
    flush_wait();
    for (int i = 0; i < 33; i++)
      cmp(swb_sdram_model_i.mem[8'h40 + 8'(i)], 32'hD0000000 + 32'(i));
    reg_wr(8'h10, 8'h00);
    {trace_on, default_pins_in} = {1'b0, 3'h2};
    $display("test full buffer done");
    // Disabling with posted data drains first and stalls the reader.
    rd_chk(26'h70, 1'b0, 32'hA5000070, 7, 7);
    hold_in = 1'b1;
    wr_chk(26'h71, 4'hF, 32'h77770000, swb_pkg::MSTR_CPU);
    reg_wr(8'h40, 8'h00);
    fork
      acc(1'b0, 26'h71, 4'h0, 32'h0, 1'b0, swb_pkg::MSTR_CPU);
      release_hold();
    join
    cmp(rd, 32'h77770000);
    cmp_cyc(cyc, 20, 400);
    $display("test disable drain done");
    // Read-ahead fetches the next line for bursts only.
    reg_wr(8'h40, 8'h08);
    base = swb_sdram_model_i.n_rd;
    rd_chk(26'h80, 1'b1, 32'hA5000080, 7, 7);
    repeat (20) tick();
    cmp(32'(swb_sdram_model_i.n_rd - base), 32'h8);
    rd_chk(26'h85, 1'b0, 32'hA5000085, 2, 2);
    base = swb_sdram_model_i.n_rd;
    rd_chk(26'h90, 1'b0, 32'hA5000090, 7, 7);
    repeat (20) tick();
    cmp(32'(swb_sdram_model_i.n_rd - base), 32'h4);
    $display("test read-ahead done");
    summarize();
  end
endmodule : swb_buffer_tb
